// ---- hdl/nvpec_pkg.sv ----
// constants and types for the nonvolatile program/erase control block
package nvpec_pkg;
    // ************************************************************
    // memory map
    // ************************************************************
    localparam logic [12:0] NVPEC_REG_LIMIT    = 13'h0020;
    localparam logic [12:0] NVPEC_EE_CTRL_ADDR = 13'h001C;
    localparam logic [12:0] NVPEC_OTP_CTRL_ADDR = 13'h001D;
    localparam logic [12:0] NVPEC_RAM_BASE     = 13'h0080;
    localparam logic [12:0] NVPEC_RAM_TOP      = 13'h00FF;
    localparam logic [12:0] NVPEC_STACK_LOW    = 13'h00C0;
    localparam logic [12:0] NVPEC_EE_BASE      = 13'h0100;
    localparam logic [12:0] NVPEC_EE_TOP       = 13'h019F;
    localparam logic [12:0] NVPEC_OTP_BASE     = 13'h0700;
    localparam logic [12:0] NVPEC_OTP_TOP      = 13'h1EFF;
    localparam logic [12:0] NVPEC_BOOT_BASE    = 13'h1F00;
    localparam logic [12:0] NVPEC_BOOT_TOP     = 13'h1FDF;
    localparam logic [12:0] NVPEC_VEC_BASE     = 13'h1FF0;
    localparam logic [12:0] NVPEC_VEC_TOP      = 13'h1FFF;
    localparam int          NVPEC_EE_BYTES     = 160;
    localparam int          NVPEC_EE_BLOCK     = 32;
    // ************************************************************
    // register fields and reset values
    // ************************************************************
    localparam int NVPEC_EE_PUMP_BIT  = 6;
    localparam int NVPEC_EE_ER1_BIT   = 4;
    localparam int NVPEC_EE_ER0_BIT   = 3;
    localparam int NVPEC_EE_LATCH_BIT = 2;
    localparam int NVPEC_EE_RC_BIT    = 1;
    localparam int NVPEC_EE_PWR_BIT   = 0;
    localparam int NVPEC_OTP_LATCH_BIT = 2;
    localparam int NVPEC_OTP_PWR_BIT   = 0;
    localparam logic [7:0] NVPEC_EE_CTRL_MASK  = 8'h5F;
    localparam logic [7:0] NVPEC_OTP_CTRL_MASK = 8'h05;
    localparam logic [7:0] NVPEC_CTRL_RESET    = 8'h00;
    localparam logic [7:0] NVPEC_OTP_ERASED    = 8'h00;
    localparam logic [7:0] NVPEC_EE_ERASED     = 8'hFF;
    localparam int         NVPEC_OTP_GROUP     = 4;
    // ************************************************************
    // erase modes
    // ************************************************************
    typedef enum logic [1:0] {
        NVPEC_ER_NONE  = 2'b00,
        NVPEC_ER_BYTE  = 2'b01,
        NVPEC_ER_BLOCK = 2'b10,
        NVPEC_ER_BULK  = 2'b11
    } nvpec_erase_t;
    // ************************************************************
    // array command sequencer
    // ************************************************************
    typedef enum logic [1:0] {
        NVPEC_ST_IDLE  = 2'b00,
        NVPEC_ST_HELD  = 2'b01,
        NVPEC_ST_APPLY = 2'b10
    } nvpec_state_t;
endpackage

// ---- hdl/nvpec_ee_op.sv ----
// one erasable-array byte slot: program (and-in zeros) or erase
`timescale 1ns/1ns
module nvpec_ee_op (
    input  wire logic [7:0] cell_i,    // current cell contents
    input  wire logic [7:0] data_i,    // held write data
    input  wire logic       hit_i,     // slot covered by selected mode
    input  wire logic       erase_i,   // mode is an erase
    input  wire logic       apply_i,   // voltage applied this cycle
    output logic      [7:0] cell_o     // next cell contents
);
    import nvpec_pkg::*;
    always_comb begin
        cell_o = cell_i;
        if (apply_i && hit_i) begin
            if (erase_i) begin
                cell_o = NVPEC_EE_ERASED;
            end else begin
                cell_o = cell_i & data_i;
            end
        end
    end
endmodule

// ---- hdl/nvpec_top.sv ----
// program/erase control for the one-time and erasable arrays
`timescale 1ns/1ns
module nvpec_top (
    input  wire logic        clk_i,          // cpu bus clock, 10 MHz
    input  wire logic        reset_n_i,      // async reset, active low
    input  wire logic [12:0] addr_i,         // cpu byte address
    input  wire logic        wr_i,           // write strobe, one cycle
    input  wire logic        rd_i,           // read strobe, one cycle
    input  wire logic [7:0]  wdata_i,        // write data
    input  wire logic [7:0]  otp_rdata_i,    // one-time array read data
    input  wire logic [7:0]  boot_rdata_i,   // bootloader rom read data
    output logic      [7:0]  rdata_o,        // read data, next cycle
    output logic             rvalid_o,       // read answer valid pulse
    output logic             otp_sel_o,      // one-time array read select
    output logic             boot_sel_o,     // bootloader read select
    output logic             otp_eprom_write_control_en_o,  // one-time programming power
    output logic [12:0]      otp_addr_o,     // held one-time word address
    output logic [3:0]       otp_bmask_o,    // bytes held in the group
    output logic [31:0]      otp_wdata_o,    // held group data
    output logic             pump_run_o,     // charge pump running
    output logic             ee_vpp_o,       // pump voltage to array
    output logic             rc_clk_sel_o    // erasable timing on rc clock
);
    import nvpec_pkg::*;

    typedef struct packed {
        logic [7:0]    ee_ctrl;
        logic [7:0]    otp_ctrl;
        logic [7:0]    rdata;
        logic          rvalid;
        logic          otp_sel;
        logic          boot_sel;
        logic          vpp;
        nvpec_state_t  ee_st;
        logic [7:0]    ee_addr;
        logic [7:0]    ee_data;
        logic [12:0]   otp_addr;
        logic [3:0]    otp_bmask;
        logic [31:0]   otp_data;
        logic [1023:0] ram;
        logic [1279:0] ee;
    } nvpec_state_s_t;

    nvpec_state_s_t st_r;
    nvpec_state_s_t st_nxt;
    logic [1279:0]  ee_next;

    // ************************************************************
    // decode
    // ************************************************************
    logic is_reg;
    logic is_ram;
    logic is_ee;
    logic is_otp;
    logic is_boot;
    logic is_vec;
    logic [7:0] ee_off;
    logic [6:0] ram_off;
    logic otp_latched;
    logic ee_latched;
    logic ee_apply;
    logic ee_erase;
    nvpec_erase_t ee_mode;

    assign is_reg  = addr_i < NVPEC_REG_LIMIT;
    assign is_ram  = addr_i >= NVPEC_RAM_BASE &&
                     addr_i <= NVPEC_RAM_TOP;
    assign is_ee   = addr_i >= NVPEC_EE_BASE &&
                     addr_i <= NVPEC_EE_TOP;
    assign is_otp  = addr_i >= NVPEC_OTP_BASE &&
                     addr_i <= NVPEC_OTP_TOP;
    assign is_vec  = addr_i >= NVPEC_VEC_BASE &&
                     addr_i <= NVPEC_VEC_TOP;
    assign is_boot = addr_i >= NVPEC_BOOT_BASE &&
                     addr_i <= NVPEC_BOOT_TOP;
    assign ee_off  = 8'((addr_i - NVPEC_EE_BASE) & 13'h00FF);
    assign ram_off = addr_i[6:0];
    assign otp_latched = st_r.otp_ctrl[NVPEC_OTP_LATCH_BIT];
    assign ee_latched  = st_r.ee_ctrl[NVPEC_EE_LATCH_BIT];
    assign ee_mode = nvpec_erase_t'({st_r.ee_ctrl[NVPEC_EE_ER1_BIT],
                                     st_r.ee_ctrl[NVPEC_EE_ER0_BIT]});
    assign ee_erase = ee_mode != NVPEC_ER_NONE;
    // pulse length is whatever software holds the power bit for
    assign ee_apply = st_r.ee_st == NVPEC_ST_APPLY &&
                      st_r.ee_ctrl[NVPEC_EE_PWR_BIT] &&
                      st_r.ee_ctrl[NVPEC_EE_PUMP_BIT];

    // ************************************************************
    // erasable array cell update
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < NVPEC_EE_BYTES; g++) begin : g_ee
            logic hit;
            always_comb begin
                case (ee_mode)
                    NVPEC_ER_BULK:  hit = 1'b1;
                    NVPEC_ER_BLOCK: hit = (g / NVPEC_EE_BLOCK) ==
                                          (int'(st_r.ee_addr) /
                                           NVPEC_EE_BLOCK);
                    default:        hit = int'(st_r.ee_addr) == g;
                endcase
            end
            nvpec_ee_op u_op (
                .cell_i  (st_r.ee[g*8 +: 8]),
                .data_i  (st_r.ee_data),
                .hit_i   (hit),
                .erase_i (ee_erase),
                .apply_i (ee_apply),
                .cell_o  (ee_next[g*8 +: 8])
            );
        end
    endgenerate

    // ************************************************************
    // next state
    // ************************************************************
    logic [7:0] w_otp;
    logic [7:0] w_ee;
    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid   = 1'b0;
        st_nxt.otp_sel  = 1'b0;
        st_nxt.boot_sel = 1'b0;
        st_nxt.ee       = ee_next;
        w_otp = wdata_i & NVPEC_OTP_CTRL_MASK;
        w_ee  = wdata_i & NVPEC_EE_CTRL_MASK;
        if (wr_i && addr_i == NVPEC_OTP_CTRL_ADDR) begin
            // power only rises on a write when the latch was already up
            if (!otp_latched) begin
                w_otp[NVPEC_OTP_PWR_BIT] = 1'b0;
            end
            if (!w_otp[NVPEC_OTP_LATCH_BIT]) begin
                w_otp[NVPEC_OTP_PWR_BIT] = 1'b0;
            end
            st_nxt.otp_ctrl = w_otp;
            if (!w_otp[NVPEC_OTP_LATCH_BIT]) begin
                // the next group must start from erased bytes
                st_nxt.otp_bmask = 4'h0;
                st_nxt.otp_data  = {NVPEC_OTP_GROUP{NVPEC_OTP_ERASED}};
            end
        end
        if (wr_i && addr_i == NVPEC_EE_CTRL_ADDR) begin
            st_nxt.ee_ctrl = w_ee;
            if (!w_ee[NVPEC_EE_LATCH_BIT]) begin
                st_nxt.ee_st = NVPEC_ST_IDLE;
            end else if (w_ee[NVPEC_EE_PWR_BIT] &&
                         st_r.ee_st != NVPEC_ST_IDLE) begin
                st_nxt.ee_st = NVPEC_ST_APPLY;
            end else if (!w_ee[NVPEC_EE_PWR_BIT] &&
                         st_r.ee_st == NVPEC_ST_APPLY) begin
                st_nxt.ee_st = NVPEC_ST_HELD;
            end
        end
        st_nxt.vpp = st_nxt.ee_ctrl[NVPEC_EE_PWR_BIT] &&
                     st_nxt.ee_ctrl[NVPEC_EE_PUMP_BIT];
        // capture writes into the one-time array group
        if (wr_i && is_otp && otp_latched) begin
            if (st_r.otp_bmask == 4'h0 ||
                addr_i[12:2] == st_r.otp_addr[12:2]) begin
                st_nxt.otp_addr = {addr_i[12:2], 2'b00};
                st_nxt.otp_bmask[addr_i[1:0]] = 1'b1;
                st_nxt.otp_data[addr_i[1:0]*8 +: 8] = wdata_i;
            end
        end
        // a write while latched only holds; the cell moves under power
        if (wr_i && is_ee && ee_latched &&
            st_r.ee_st == NVPEC_ST_IDLE) begin
            st_nxt.ee_addr = ee_off;
            st_nxt.ee_data = wdata_i;
            st_nxt.ee_st   = NVPEC_ST_HELD;
        end
        if (wr_i && is_ram) begin
            st_nxt.ram[ram_off*8 +: 8] = wdata_i;
        end
        if (rd_i) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = 8'h00;
            if (addr_i == NVPEC_OTP_CTRL_ADDR) begin
                st_nxt.rdata = st_r.otp_ctrl;
            end else if (addr_i == NVPEC_EE_CTRL_ADDR) begin
                st_nxt.rdata = st_r.ee_ctrl;
            end else if (is_ram) begin
                st_nxt.rdata = st_r.ram[ram_off*8 +: 8];
            end else if (is_ee) begin
                if (!ee_latched) begin
                    st_nxt.rdata = st_r.ee[int'(ee_off)*8 +: 8];
                end
            end else if (is_otp || is_vec) begin
                st_nxt.otp_sel = !otp_latched;
            end else if (is_boot) begin
                st_nxt.boot_sel = !otp_latched;
            end
        end
    end

    // ************************************************************
    // state registers
    // ************************************************************
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r    <= '0;
            // the cell model does not outlive reset; it comes back erased
            st_r.ee <= {NVPEC_EE_BYTES{NVPEC_EE_ERASED}};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = st_r.rdata;
        if (st_r.otp_sel) begin
            rd_mux = otp_rdata_i;
        end else if (st_r.boot_sel) begin
            rd_mux = boot_rdata_i;
        end
    end
    assign rdata_o       = rd_mux;
    assign rvalid_o      = st_r.rvalid;
    assign otp_sel_o     = st_r.otp_sel;
    assign boot_sel_o    = st_r.boot_sel;
    assign otp_eprom_write_control_en_o = st_r.otp_ctrl[NVPEC_OTP_PWR_BIT];
    assign otp_addr_o    = st_r.otp_addr;
    assign otp_bmask_o   = st_r.otp_bmask;
    // unwritten group bytes stay at the erased value, so nothing moves
    assign otp_wdata_o   = st_r.otp_data;
    assign pump_run_o    = st_r.ee_ctrl[NVPEC_EE_PUMP_BIT];
    assign ee_vpp_o      = st_r.vpp;
    assign rc_clk_sel_o  = st_r.ee_ctrl[NVPEC_EE_RC_BIT];

    // ************************************************************
    // checks
    // ************************************************************
    power_needs_latch_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        otp_eprom_write_control_en_o |-> otp_latched)
        else $error("otp power set without latch");
    same_write_set_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (wr_i && addr_i == NVPEC_OTP_CTRL_ADDR && !otp_latched)
        |=> !otp_eprom_write_control_en_o)
        else $error("otp power set with latch");
    unlatch_clears_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        $fell(otp_latched) |-> !otp_eprom_write_control_en_o)
        else $error("otp power survived unlatch");
    ee_read_block_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (rd_i && is_ee && ee_latched) |=> rvalid_o && rdata_o == 8'h00)
        else $error("erasable read while latched");
    otp_read_block_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (rd_i && (is_otp || is_boot) && otp_latched)
        |=> !otp_sel_o && !boot_sel_o)
        else $error("one-time array read while latched");
    vpp_follows_bit_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        ee_vpp_o == (st_r.ee_ctrl[NVPEC_EE_PWR_BIT] && pump_run_o))
        else $error("pump voltage mismatch");
    group_same_word_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (otp_bmask_o != 4'h0 && $past(otp_bmask_o) != 4'h0)
        |-> otp_addr_o == $past(otp_addr_o))
        else $error("group address moved");
    ram_roundtrip_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (wr_i && is_ram) ##1 (rd_i && addr_i == $past(addr_i))
        |=> rdata_o == $past(wdata_i, 2))
        else $error("ram read back mismatch");
    spare_reg_zero_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (rd_i && is_reg && addr_i != NVPEC_EE_CTRL_ADDR &&
         addr_i != NVPEC_OTP_CTRL_ADDR) |=> rdata_o == 8'h00)
        else $error("spare register read not zero");
    pump_off_dark_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !pump_run_o |-> !ee_vpp_o)
        else $error("array voltage without pump");
    group_clear_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        otp_bmask_o == 4'h0
        |-> otp_wdata_o == {NVPEC_OTP_GROUP{NVPEC_OTP_ERASED}})
        else $error("idle one-time group not erased");
endmodule

// ---- test/nvpec_top_tb_top.sv ----
// self-checking bench for the nonvolatile program/erase control block
`timescale 1ns/1ns
module nvpec_top_tb_top;
    import nvpec_pkg::*;
    logic        clk_i;
    logic        reset_n_i;
    logic [12:0] addr_i;
    logic        wr_i;
    logic        rd_i;
    logic [7:0]  wdata_i;
    logic [7:0]  otp_rdata_i;
    logic [7:0]  boot_rdata_i;
    logic [7:0]  rdata_o;
    logic        rvalid_o;
    logic        otp_sel_o;
    logic        boot_sel_o;
    logic        otp_eprom_write_control_en_o;
    logic [12:0] otp_addr_o;
    logic [3:0]  otp_bmask_o;
    logic [31:0] otp_wdata_o;
    logic        pump_run_o;
    logic        ee_vpp_o;
    logic        rc_clk_sel_o;
    int          errors;
    int          num_checks;
    logic [7:0]  rd_val;
    logic        rd_otp;
    logic        rd_boot;

    nvpec_top nvpec_top_inst (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
        .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
        .otp_rdata_i(otp_rdata_i), .boot_rdata_i(boot_rdata_i),
        .rdata_o(rdata_o), .rvalid_o(rvalid_o), .otp_sel_o(otp_sel_o),
        .boot_sel_o(boot_sel_o), .otp_eprom_write_control_en_o(otp_eprom_write_control_en_o),
        .otp_addr_o(otp_addr_o), .otp_bmask_o(otp_bmask_o),
        .otp_wdata_o(otp_wdata_o), .pump_run_o(pump_run_o),
        .ee_vpp_o(ee_vpp_o), .rc_clk_sel_o(rc_clk_sel_o)
    );

    // ************************************************************
    // bus tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s: expected %0h, seen %0h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    // write, then read the same byte at the very next edge
    task automatic wr_rd(input logic [12:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
        rd_i    <= 1'b1;
        @(posedge clk_i);
        rd_i    <= 1'b0;
        #10;
        chk("read valid", 32'h1, {31'h0, rvalid_o});
        rd_val = rdata_o;
    endtask

    // answer is sampled 10 ns after the edge that raised rvalid_o
    task automatic rd(input logic [12:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #10;
        chk("read valid", 32'h1, {31'h0, rvalid_o});
        rd_val  = rdata_o;
        rd_otp  = otp_sel_o;
        rd_boot = boot_sel_o;
    endtask

    task automatic rdchk(input logic [12:0] a, input logic [7:0] exp);
        rd(a);
        chk($sformatf("read %0h", a), {24'h0, exp}, {24'h0, rd_val});
    endtask

    task automatic done_test(input string nm);
        $display("test %s done, mismatches so far %0d", nm, errors);
    endtask

    // full sequence: latch and pump, write, hold power a few cycles, drop
    task automatic ee_seq(input nvpec_erase_t m, input logic [12:0] a,
                          input logic [7:0] d);
        logic [7:0] ctrl;
        ctrl = {3'b010, m, 3'b100};
        wr(NVPEC_EE_CTRL_ADDR, ctrl);
        #10 chk("pump run", 32'h1, {31'h0, pump_run_o});
        wr(a, d);
        rdchk(a, 8'h00);
        wr(NVPEC_EE_CTRL_ADDR, ctrl | 8'h01);
        #10 chk("array voltage on", 32'h1, {31'h0, ee_vpp_o});
        repeat (3) @(posedge clk_i);
        chk("voltage held", 32'h1, {31'h0, ee_vpp_o});
        wr(NVPEC_EE_CTRL_ADDR, ctrl);
        #10 chk("array voltage off", 32'h0, {31'h0, ee_vpp_o});
        wr(NVPEC_EE_CTRL_ADDR, 8'h00);
        #10 chk("pump off", 32'h0, {31'h0, pump_run_o});
    endtask

    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ************************************************************
    // clock and watchdog
    // ************************************************************
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        errors++;
        wrap_up();
    end

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        errors = 0;
        num_checks = 0;
        reset_n_i = 1'b0;
        addr_i = 13'h0000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        wdata_i = 8'h00;
        otp_rdata_i = 8'h5A;
        boot_rdata_i = 8'hC3;
        repeat (5) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rdchk(NVPEC_EE_CTRL_ADDR, NVPEC_CTRL_RESET);
        rdchk(NVPEC_OTP_CTRL_ADDR, NVPEC_CTRL_RESET);
        wr(NVPEC_EE_CTRL_ADDR, 8'hFA);
        rdchk(NVPEC_EE_CTRL_ADDR, 8'hFA & NVPEC_EE_CTRL_MASK);
        chk("rc clock select", 32'h1, {31'h0, rc_clk_sel_o});
        chk("no voltage", 32'h0, {31'h0, ee_vpp_o});
        wr(NVPEC_EE_CTRL_ADDR, 8'h00);
        #10 chk("cpu clock select", 32'h0, {31'h0, rc_clk_sel_o});
        rdchk(13'h001E, 8'h00);
        rdchk(13'h0200, 8'h00);
        done_test("registers");
        rdchk(NVPEC_RAM_BASE, 8'h00);
        wr(NVPEC_STACK_LOW, 8'h96);
        wr(NVPEC_RAM_TOP, 8'h69);
        rdchk(NVPEC_STACK_LOW, 8'h96);
        rdchk(NVPEC_RAM_TOP, 8'h69);
        wr_rd(13'h00A7, 8'h5C);
        chk("ram back to back", 32'h5C, {24'h0, rd_val});
        done_test("ram");
        wr(NVPEC_OTP_CTRL_ADDR, 8'h05);
        rdchk(NVPEC_OTP_CTRL_ADDR, 8'h04);
        chk("otp power", 32'h0, {31'h0, otp_eprom_write_control_en_o});
        rd(NVPEC_BOOT_BASE);
        chk("boot blocked", 32'h0, {23'h0, rd_boot, rd_val});
        wr(13'h0705, 8'hA5);
        wr(13'h0707, 8'h3C);
        wr(13'h0709, 8'h77);
        chk("otp word", 32'h0704, {19'h0, otp_addr_o});
        chk("otp mask", 32'hA, {28'h0, otp_bmask_o});
        chk("otp data", 32'h3C00A500, otp_wdata_o);
        rd(13'h0705);
        chk("otp blocked", 32'h0, {23'h0, rd_otp, rd_val});
        wr(NVPEC_OTP_CTRL_ADDR, 8'h05);
        rdchk(NVPEC_OTP_CTRL_ADDR, 8'h05);
        chk("otp power on", 32'h1, {31'h0, otp_eprom_write_control_en_o});
        wr(NVPEC_OTP_CTRL_ADDR, 8'h01);
        #10 chk("otp power off", 32'h0, {31'h0, otp_eprom_write_control_en_o});
        chk("otp mask clear", 32'h0, {28'h0, otp_bmask_o});
        chk("otp data clear", 32'h0, otp_wdata_o);
        rdchk(NVPEC_OTP_CTRL_ADDR, NVPEC_CTRL_RESET);
        wr(NVPEC_OTP_CTRL_ADDR, 8'h01);
        rdchk(NVPEC_OTP_CTRL_ADDR, NVPEC_CTRL_RESET);
        wr(NVPEC_OTP_CTRL_ADDR, 8'h04);
        wr(13'h0712, 8'h5A);
        #10 chk("new group", 32'h005A0000, otp_wdata_o);
        chk("new word", 32'h0710, {19'h0, otp_addr_o});
        wr(NVPEC_OTP_CTRL_ADDR, 8'h00);
        rd(NVPEC_OTP_BASE);
        chk("otp read", 32'h15A, {23'h0, rd_otp, rd_val});
        rd(NVPEC_VEC_TOP);
        chk("vector read", 32'h15A, {23'h0, rd_otp, rd_val});
        rd(NVPEC_BOOT_TOP);
        chk("boot read", 32'h1C3, {23'h0, rd_boot, rd_val});
        rdchk(13'h06FF, 8'h00);
        done_test("one-time array");
        ee_seq(NVPEC_ER_BULK, 13'h0150, 8'h00);
        rdchk(NVPEC_EE_BASE, NVPEC_EE_ERASED);
        rdchk(NVPEC_EE_TOP, NVPEC_EE_ERASED);
        ee_seq(NVPEC_ER_NONE, 13'h0120, 8'hA5);
        rdchk(13'h0120, 8'hA5);
        ee_seq(NVPEC_ER_NONE, 13'h0120, 8'h3C);
        rdchk(13'h0120, 8'hA5 & 8'h3C);
        ee_seq(NVPEC_ER_NONE, 13'h0140, 8'h00);
        ee_seq(NVPEC_ER_BYTE, 13'h0120, 8'h00);
        rdchk(13'h0120, NVPEC_EE_ERASED);
        rdchk(13'h0140, 8'h00);
        ee_seq(NVPEC_ER_NONE, 13'h0121, 8'h0F);
        ee_seq(NVPEC_ER_BLOCK, 13'h013F, 8'h00);
        rdchk(13'h0121, NVPEC_EE_ERASED);
        rdchk(13'h0140, 8'h00);
        done_test("erasable array");
        // a second reset mid-run must drop every control bit again
        wr(NVPEC_EE_CTRL_ADDR, 8'h46);
        wr(NVPEC_OTP_CTRL_ADDR, 8'h04);
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        #10 chk("pump after reset", 32'h0, {31'h0, pump_run_o});
        rdchk(NVPEC_EE_CTRL_ADDR, NVPEC_CTRL_RESET);
        rdchk(NVPEC_OTP_CTRL_ADDR, NVPEC_CTRL_RESET);
        rdchk(NVPEC_EE_BASE, NVPEC_EE_ERASED);
        done_test("reset");
        wrap_up();
    end
endmodule
